// ---- shared/scfm_consts.vh ----
// Timing and sizing constants for the signal conflict fault monitor
`ifndef SCFM_CONSTS_VH
`define SCFM_CONSTS_VH
// ==========================================================
// Clock and millisecond tick
`define SCFM_CLK_PERIOD_NS 10
`define SCFM_MS_NS 1000000
`define SCFM_MS_CYCLES (`SCFM_MS_NS / `SCFM_CLK_PERIOD_NS)
// ==========================================================
// Qualification times, ms
`define SCFM_FIELD_ON_MS 10'h1f4
`define SCFM_FIELD_OFF_MS 10'h0c8
`define SCFM_INH_ON_MS 10'h226
`define SCFM_INH_OFF_MS 10'h0fa
// ==========================================================
// Fault times, ms, and watchdog toggle count
`define SCFM_RF_TYPE1_MS 11'h384
`define SCFM_RF_TYPE2_MS 11'h578
`define SCFM_CLEAR_MS 12'ha8c
`define SCFM_DUAL_MS 9'h15e
`define SCFM_CFG_HOLD_MS 12'hbb8
`define SCFM_FLASH_MIN_MS 14'h1770
`define SCFM_FLASH_MAX_MS 14'h2710
`define SCFM_WD_TOGGLES 3'h5
// ==========================================================
// Indicator blink, ms (2 Hz period 500, 4 Hz period 250)
`define SCFM_BLINK_PERIOD_MS 9'h1f4
`define SCFM_BLINK2_HALF_MS 9'h0fa
`define SCFM_BLINK4_HALF_MS 9'h07d
// ==========================================================
// Reset values
`define SCFM_CHAN_RST 18'h00000
`endif

// ---- rtl/scfm_qual.v ----
// Duration qualifier: an input counts as on after its raw level persists
`timescale 1ns/10ps
`default_nettype none
module scfm_qual #(
  parameter ON_MS = 500,
  parameter W = 10
) (
  // Clock, reset, tick
  input wire clk_sys_i,
  input wire rst_i,
  input wire tick_i,
  // Level
  input wire raw_i,
  output reg qual_o
);
  localparam [W-1:0] ON_CNT = ON_MS[W-1:0];
  reg [W-1:0] cnt_q;

  // A raw drop restarts the count, so short pulses never qualify
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q <= {W{1'b0}};
      qual_o <= 1'b0;
    end else if (!raw_i) begin
      cnt_q <= {W{1'b0}};
      qual_o <= 1'b0;
    end else begin
      if (tick_i && cnt_q != ON_CNT)
        cnt_q <= cnt_q + 1'b1;
      qual_o <= (cnt_q == ON_CNT);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/scfm_top.v ----
// Signal conflict monitor fault detection, flash interval and indicators
// Function
// - Red interface cable removal latches a fault and forces cabinet flash.
// - Either active inhibit suppresses red failure checking only.
// - Inhibit active after 550 ms on; under 250 ms counts inactive.
// - Field inputs qualify on after 500 ms; under 200 ms stay off.
// - Triggered faults hold until panel or remote reset.
// - No indication on a channel past the type limit triggers red failure.
// - Red failure checking enabled per channel by switch.
// - Red failure runs only with gate active, no inhibit, relay common inactive.
// - Green not followed by 2.7 s of yellow triggers clearance fault.
// - Clearance enabled per channel; off for yellow inhibit, gate off, relay common.
// - Two indications on together over 350 ms trigger dual fault; not under 200.
// - GYR dual per channel, GY dual global; off when gate off or relay common.
// - Configuration compared with stored copy; mismatch triggers, card indicator flashes.
// - Configuration fault clears only after 3 s panel reset hold.
// - Supply drop-out triggers and blinks power indicator 2 Hz 50%.
// - Supply restore resumes operation after the flash interval; power indicator blinks 4 Hz in it, then steady on.
// - Latched faults survive a line interruption unchanged.
// - Power-up, interruption or restore starts 6-10 s flash interval.
// - Flash interval ends after 6 s, 5 watchdog toggles and supply restored.
// - Fewer than 5 toggles within 10 s gives watchdog toggle fault.
// - Switch selects arrow mode; per-phase switches enable arrow monitoring.
// - Standard arrow mode maps phases 1,3,5,7 to channels 9-12.
`timescale 1ns/10ps
`default_nettype none
`include "scfm_consts.vh"
module scfm_top #(
  parameter NCH = 18,
  parameter CFGW = 32,
  parameter MS_CYCLES = `SCFM_MS_CYCLES
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // Field inputs, already reduced to on/off
  input wire [NCH-1:0] red_i,
  input wire [NCH-1:0] yel_i,
  input wire [NCH-1:0] grn_i,
  input wire red_gate_i,
  input wire inhibit1_i,
  input wire inhibit2_i,
  input wire relay_common_sense_i,
  input wire red_interface_cable_i,
  input wire watchdog_i,
  input wire line_ok_i,
  // Configuration switches
  input wire ctrl_type2_i,
  input wire [NCH-1:0] red_fail_en_i,
  input wire [NCH-1:0] clear_en_i,
  input wire [NCH-1:0] yellow_inhibit_i,
  input wire [NCH-1:0] dual_en_i,
  input wire gy_dual_en_i,
  input wire arrow_head_compact_mode_i,
  input wire [3:0] arrow_phase_en_i,
  input wire [CFGW-1:0] cfg_i,
  // Resets from panel and remote
  input wire panel_reset_i,
  input wire remote_reset_i,
  // Fault and indicator outputs
  output reg cabinet_flash_o,
  output reg triggered_o,
  output reg fault_cable_o,
  output reg fault_red_fail_o,
  output reg fault_clear_o,
  output reg fault_dual_o,
  output reg fault_cfg_o,
  output reg fault_power_o,
  output reg watchdog_toggle_fault_o,
  output reg power_led_o,
  output reg program_card_led_o,
  output reg [NCH-1:0] fail_chan_o,
  output reg [NCH-1:0] stat_red_o,
  output reg [NCH-1:0] stat_yel_o,
  output reg [NCH-1:0] stat_grn_o
);
  localparam [1:0] ST_FLASH = 2'd0;
  localparam [1:0] ST_RUN = 2'd1;
  localparam [1:0] ST_DROP = 2'd2;
  localparam [10:0] RF1 = `SCFM_RF_TYPE1_MS;
  localparam [10:0] RF2 = `SCFM_RF_TYPE2_MS;
  localparam [11:0] CLR_MS = `SCFM_CLEAR_MS;
  localparam [8:0] DUAL_MS = `SCFM_DUAL_MS;
  localparam [11:0] HOLD_MS = `SCFM_CFG_HOLD_MS;
  localparam [13:0] FL_MIN = `SCFM_FLASH_MIN_MS;
  localparam [13:0] FL_MAX = `SCFM_FLASH_MAX_MS;
  localparam [2:0] WD_N = `SCFM_WD_TOGGLES;
  localparam [8:0] BL_PER = `SCFM_BLINK_PERIOD_MS;
  localparam [8:0] BL2 = `SCFM_BLINK2_HALF_MS;
  localparam [8:0] BL4 = `SCFM_BLINK4_HALF_MS;

  // ==========================================================
  // Millisecond tick
  reg [31:0] div_q;
  reg tick_q;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (div_q == MS_CYCLES - 1) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================
  // Input qualification
  wire [NCH-1:0] qr, qy, qg;
  wire inh1, inh2, gate;
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_q
      scfm_qual #(.ON_MS(`SCFM_FIELD_ON_MS), .W(10)) u_r (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .tick_i(tick_q), .raw_i(red_i[c]), .qual_o(qr[c]));
      scfm_qual #(.ON_MS(`SCFM_FIELD_ON_MS), .W(10)) u_y (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .tick_i(tick_q), .raw_i(yel_i[c]), .qual_o(qy[c]));
      scfm_qual #(.ON_MS(`SCFM_FIELD_ON_MS), .W(10)) u_g (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .tick_i(tick_q), .raw_i(grn_i[c]), .qual_o(qg[c]));
    end
  endgenerate
  scfm_qual #(.ON_MS(`SCFM_INH_ON_MS), .W(10)) u_i1 (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .tick_i(tick_q), .raw_i(inhibit1_i), .qual_o(inh1));
  scfm_qual #(.ON_MS(`SCFM_INH_ON_MS), .W(10)) u_i2 (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .tick_i(tick_q), .raw_i(inhibit2_i), .qual_o(inh2));
  scfm_qual #(.ON_MS(`SCFM_FIELD_ON_MS), .W(10)) u_gt (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .tick_i(tick_q), .raw_i(red_gate_i), .qual_o(gate));

  // ==========================================================
  // Arrow-head mapping: the arrow channel's green also carries the solid arrow
  reg [NCH-1:0] eg;
  integer p;
  integer ac;
  reg src;
  always @* begin
    eg = qg;
    ac = 0;
    src = 1'b0;
    for (p = 0; p < 4; p = p + 1) begin
      if (arrow_phase_en_i[p]) begin
        if (arrow_head_compact_mode_i) begin
          ac = 2 * p;
          src = p[0] ? qy[8 + p / 2] : qg[8 + p / 2];
        end else begin
          ac = 8 + p;
          src = qg[2 * p];
        end
        eg[ac] = qg[ac] | src;
      end
    end
  end

  // ==========================================================
  // Per-channel checks
  reg [1:0] st_q;
  wire mon = (st_q == ST_RUN);
  wire rf_run = mon & gate & ~inh1 & ~inh2 & ~relay_common_sense_i;
  wire ck_run = mon & gate & ~relay_common_sense_i;
  wire [10:0] rf_lim = ctrl_type2_i ? RF2 : RF1;
  wire [NCH-1:0] rf_hit, cl_hit, du_hit;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      reg [10:0] rf_q;
      reg gseen_q;
      reg [11:0] yc_q;
      reg [8:0] du_q;
      wire none = ~(qr[c] | qy[c] | eg[c]);
      wire cl_on = ck_run & clear_en_i[c] & ~yellow_inhibit_i[c];
      wire pair = (dual_en_i[c] & ((qr[c] & qy[c]) | (qr[c] & eg[c]) | (qy[c] & eg[c])))
                | (gy_dual_en_i & qy[c] & eg[c]);
      assign rf_hit[c] = (rf_q == rf_lim);
      assign cl_hit[c] = cl_on & gseen_q & ~eg[c] & ~qy[c] & (qr[c] | (yc_q != 12'h000))
                       & (yc_q != CLR_MS);
      assign du_hit[c] = (du_q == DUAL_MS);
      always @(posedge clk_sys_i) begin
        if (rst_i) begin
          rf_q <= 11'h000;
          gseen_q <= 1'b0;
          yc_q <= 12'h000;
          du_q <= 9'h000;
        end else begin
          if (!rf_run || !red_fail_en_i[c] || !none)
            rf_q <= 11'h000;
          else if (tick_q && rf_q != rf_lim)
            rf_q <= rf_q + 11'h001;
          if (!cl_on) begin
            gseen_q <= 1'b0;
            yc_q <= 12'h000;
          end else if (eg[c]) begin
            gseen_q <= 1'b1;
            yc_q <= 12'h000;
          end else if (gseen_q && qy[c]) begin
            if (tick_q && yc_q != CLR_MS)
              yc_q <= yc_q + 12'h001;
          end else if (gseen_q && (qr[c] || yc_q != 12'h000)) begin
            gseen_q <= 1'b0;
            yc_q <= 12'h000;
          end
          if (!ck_run || !pair)
            du_q <= 9'h000;
          else if (tick_q && du_q != DUAL_MS)
            du_q <= du_q + 9'h001;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Flash interval and supply state
  reg [13:0] fl_q;
  reg [2:0] wd_q;
  reg wd_prev_q;
  wire fl_end = (fl_q >= FL_MIN) & (wd_q >= WD_N) & line_ok_i;
  wire wd_late = (fl_q >= FL_MAX) & (wd_q < WD_N);
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= ST_FLASH;
      fl_q <= 14'h0000;
      wd_q <= 3'h0;
      // Track the pin in reset so an idle-high watchdog gives no false toggle
      wd_prev_q <= watchdog_i;
    end else begin
      wd_prev_q <= watchdog_i;
      case (st_q)
        ST_FLASH: begin
          if (tick_q && fl_q != FL_MAX)
            fl_q <= fl_q + 14'h0001;
          if (watchdog_i != wd_prev_q && wd_q != WD_N)
            wd_q <= wd_q + 3'h1;
          if (!line_ok_i)
            st_q <= ST_DROP;
          else if (fl_end || wd_late)
            st_q <= ST_RUN;
        end
        ST_RUN: begin
          if (!line_ok_i)
            st_q <= ST_DROP;
        end
        default: begin
          fl_q <= 14'h0000;
          wd_q <= 3'h0;
          if (line_ok_i)
            st_q <= ST_FLASH;
        end
      endcase
    end
  end

  // ==========================================================
  // Configuration copy and long panel-reset hold
  reg [CFGW-1:0] cfg_q;
  reg cap_q;
  reg [11:0] hold_q;
  wire hold_done = (hold_q == HOLD_MS);
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_q <= {CFGW{1'b0}};
      cap_q <= 1'b0;
      hold_q <= 12'h000;
    end else begin
      if (!panel_reset_i)
        hold_q <= 12'h000;
      else if (tick_q && !hold_done)
        hold_q <= hold_q + 12'h001;
      // Copy is taken after each power-up; a hold accepts the new settings
      if (!cap_q || hold_done) begin
        cfg_q <= cfg_i;
        cap_q <= 1'b1;
      end
    end
  end
  wire cfg_diff = cap_q & (cfg_i != cfg_q);

  // ==========================================================
  // Latched faults; set wins over reset except where the 3 s hold clears the configuration fault, supply loss never clears them
  wire clr = panel_reset_i | remote_reset_i;
  wire any_trig = fault_cable_o | fault_red_fail_o | fault_clear_o | fault_dual_o
                | fault_cfg_o | watchdog_toggle_fault_o;
  reg [8:0] bl_q;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_cable_o <= 1'b0;
      fault_red_fail_o <= 1'b0;
      fault_clear_o <= 1'b0;
      fault_dual_o <= 1'b0;
      fault_cfg_o <= 1'b0;
      fault_power_o <= 1'b0;
      watchdog_toggle_fault_o <= 1'b0;
      fail_chan_o <= `SCFM_CHAN_RST;
      stat_red_o <= `SCFM_CHAN_RST;
      stat_yel_o <= `SCFM_CHAN_RST;
      stat_grn_o <= `SCFM_CHAN_RST;
      triggered_o <= 1'b0;
      cabinet_flash_o <= 1'b1;
      power_led_o <= 1'b0;
      program_card_led_o <= 1'b0;
      bl_q <= 9'h000;
    end else begin
      fault_cable_o <= (fault_cable_o & ~clr) | ~red_interface_cable_i;
      fault_red_fail_o <= (fault_red_fail_o & ~clr) | (|rf_hit);
      fault_clear_o <= (fault_clear_o & ~clr) | (|cl_hit);
      fault_dual_o <= (fault_dual_o & ~clr) | (|du_hit);
      watchdog_toggle_fault_o <= (watchdog_toggle_fault_o & ~clr)
                               | (st_q == ST_FLASH & wd_late);
      if (hold_done)
        fault_cfg_o <= 1'b0;
      else if (cfg_diff)
        fault_cfg_o <= 1'b1;
      fault_power_o <= (st_q == ST_DROP);
      if (clr && !(|rf_hit) && !(|cl_hit) && !(|du_hit))
        fail_chan_o <= `SCFM_CHAN_RST;
      else
        fail_chan_o <= fail_chan_o | rf_hit | cl_hit | du_hit;
      // Channel status freezes at the trigger so the cause stays visible
      if (!any_trig) begin
        stat_red_o <= qr;
        stat_yel_o <= qy;
        stat_grn_o <= qg;
      end
      triggered_o <= any_trig | (st_q == ST_DROP);
      cabinet_flash_o <= any_trig | (st_q != ST_RUN);
      if (tick_q)
        bl_q <= (bl_q == BL_PER - 9'h001) ? 9'h000 : bl_q + 9'h001;
      if (st_q == ST_DROP)
        power_led_o <= (bl_q < BL2);
      else if (st_q == ST_FLASH)
        power_led_o <= (bl_q < BL4) | ((bl_q >= BL2) & (bl_q < BL2 + BL4));
      else
        power_led_o <= 1'b1;
      program_card_led_o <= fault_cfg_o & (bl_q < BL2);
    end
  end
endmodule
`default_nettype wire

// ---- verif/scfm_ctrl_model.sv ----
// Controller model that toggles the watchdog line
`timescale 1ns/10ps
`default_nettype none
module scfm_ctrl_model #(
  parameter int HALF = 400
) (
  // Clock and enable
  input wire logic clk_sys_i,
  input wire logic en_i,
  // Watchdog level to the monitor
  output var logic watchdog_o
);
  int cnt_q = 0;
  logic lvl_q = 1'h0;
  assign watchdog_o = lvl_q;
  // Held still while disabled, so the monitor sees no toggles at all
  always @(posedge clk_sys_i) begin
    if (en_i) begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HALF - 1) lvl_q <= ~lvl_q;
    end
  end
endmodule
`default_nettype wire

// ---- verif/scfm_top_asserts.sv ----
// Concurrent checks on the fault monitor top ports
`timescale 1ns/10ps
`default_nettype none
module scfm_top_chk #(
  parameter int MS_CYCLES = 100000
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Inputs
  input wire logic red_interface_cable_i,
  input wire logic line_ok_i,
  input wire logic panel_reset_i,
  input wire logic remote_reset_i,
  // Outputs
  input wire logic cabinet_flash_o,
  input wire logic triggered_o,
  input wire logic fault_cable_o,
  input wire logic fault_red_fail_o,
  input wire logic fault_clear_o,
  input wire logic fault_dual_o,
  input wire logic fault_cfg_o,
  input wire logic watchdog_toggle_fault_o,
  input wire logic power_led_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  int cyc_q, pr_q, lo_q, led_q;
  logic led_p_q;
  wire logic quiet = !panel_reset_i && !remote_reset_i;
  wire logic [3:0] held = {fault_red_fail_o, fault_dual_o, fault_clear_o, watchdog_toggle_fault_o};
  wire logic any_f = |{held, fault_cable_o, fault_cfg_o};
  // ====
  // Counters: since reset, panel held, supply low, indicator unchanged
  always @(posedge clk_sys_i) begin
    cyc_q <= rst_i ? 0 : cyc_q + (cyc_q < 2000000000);
    pr_q <= panel_reset_i ? pr_q + 1 : 0;
    lo_q <= line_ok_i ? 0 : lo_q + 1;
    led_p_q <= power_led_o;
    led_q <= (power_led_o != led_p_q) ? 0 : led_q + 1;
  end
  cable_latch_a: assert property ($rose(fault_cable_o) |->
    !$past(red_interface_cable_i) || !$past(red_interface_cable_i, 2))
    else $error("cable fault rose with cable present");
  fault_flash_a: assert property (any_f && $past(any_f) |-> cabinet_flash_o && triggered_o)
    else $error("latched fault without flash");
  fault_hold_a: assert property (quiet [*3] |-> ($past(held) & ~held) == 4'h0)
    else $error("fault flag lost without reset");
  cfg_keep_a: assert property (!panel_reset_i [*3] ##0 $past(fault_cfg_o) |-> fault_cfg_o)
    else $error("config fault cleared without panel hold");
  cfg_hold_a: assert property ($fell(fault_cfg_o) && !$past(rst_i) |->
    pr_q >= 2999 * MS_CYCLES) else $error("config fault cleared by short hold");
  flash_hold_a: assert property (cyc_q < 6000 * MS_CYCLES |-> cabinet_flash_o)
    else $error("flash interval ended early");
  wd_time_a: assert property ($rose(watchdog_toggle_fault_o) |-> cyc_q >= 9500 * MS_CYCLES)
    else $error("watchdog fault too early");
  drop_trig_a: assert property ($fell(line_ok_i) |-> ##[1:4] triggered_o)
    else $error("supply drop not triggered");
  drop_blink_a: assert property (lo_q > 300 * MS_CYCLES |-> led_q <= 251 * MS_CYCLES)
    else $error("power indicator not blinking");
endmodule
bind scfm_top scfm_top_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);
`default_nettype wire

// ---- verif/tb_signal_conflict_fault_monitor.sv ----
// Self-checking bench for the signal conflict fault monitor
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_signal_conflict_fault_monitor;
  localparam int MS = 2;
  logic clk_sys_i = 1'h0, rst_i = 1'h1, watchdog_i, wd_en = 1'h0;
  logic [17:0] red_i = 18'h3ffff, yel_i = 18'h0, grn_i = 18'h0, yellow_inhibit_i = 18'h0;
  logic [17:0] red_fail_en_i = 18'h3ffff, clear_en_i = 18'h3ffff, dual_en_i = 18'h3ffff;
  logic red_gate_i = 1'h1, inhibit1_i = 1'h0, inhibit2_i = 1'h0, relay_common_sense_i = 1'h0;
  logic red_interface_cable_i = 1'h1, line_ok_i = 1'h1, ctrl_type2_i = 1'h0;
  logic gy_dual_en_i = 1'h0, arrow_head_compact_mode_i = 1'h0;
  logic panel_reset_i = 1'h0, remote_reset_i = 1'h0;
  logic [3:0] arrow_phase_en_i = 4'h0;
  logic [31:0] cfg_i = 32'h0;
  logic cabinet_flash_o, triggered_o, fault_cable_o, fault_red_fail_o, fault_clear_o;
  logic fault_dual_o, fault_cfg_o, fault_power_o, watchdog_toggle_fault_o;
  logic power_led_o, program_card_led_o, seen;
  logic [17:0] fail_chan_o, stat_red_o, stat_yel_o, stat_grn_o;
  int n_errors = 0, checks = 0, n, c, lo, hi;
  always #5 clk_sys_i = ~clk_sys_i;
  scfm_top #(.MS_CYCLES(MS)) u_dut (.*);
  scfm_ctrl_model #(.HALF(200 * MS)) u_ctrl (.clk_sys_i(clk_sys_i), .en_i(wd_en),
    .watchdog_o(watchdog_i));
  task automatic ms(input int k);
    repeat (k * MS) @(posedge clk_sys_i);
  endtask
  task automatic rreset;
    remote_reset_i <= 1'h1;
    ms(5);
    remote_reset_i <= 1'h0;
    ms(5);
  endtask
  task automatic complete_run;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====
  // Main sequence
  initial begin
    void'($urandom(58));
    ctrl_type2_i <= 1'($urandom);
    {arrow_head_compact_mode_i, gy_dual_en_i, arrow_phase_en_i} <= 6'($urandom);
    yellow_inhibit_i <= 18'($urandom);
    cfg_i <= $urandom;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    ms(9400);
    `CHK(cabinet_flash_o, 1'h1)
    `CHK(watchdog_toggle_fault_o, 1'h0)
    seen = power_led_o;
    ms(125);
    `CHK(power_led_o, !seen)
    ms(1200);
    `CHK(watchdog_toggle_fault_o, 1'h1)
    line_ok_i <= 1'h0;
    ms(600);
    `CHK(triggered_o, 1'h1)
    `CHK(fault_power_o, 1'h1)
    seen = power_led_o;
    ms(250);
    `CHK(power_led_o, !seen)
    wd_en <= 1'h1;
    line_ok_i <= 1'h1;
    ms(10);
    `CHK(watchdog_toggle_fault_o, 1'h1)
    rreset;
    n = 20 * MS;
    while (cabinet_flash_o !== 1'h0 && n < 11000 * MS) begin
      @(posedge clk_sys_i);
      n++;
    end
    `CHK(cabinet_flash_o, 1'h0)
    `CHK(n >= 6000 * MS, 1'b1)
    ms(300);
    `CHK(power_led_o, 1'h1)
    c = 12 + $urandom % 6;
    lo = ctrl_type2_i ? 1200 : 750;
    hi = ctrl_type2_i ? 1500 : 1000;
    {inhibit2_i, inhibit1_i} <= 2'h1 << ($urandom % 2);
    ms(600);
    red_i[c] <= 1'h0;
    ms(hi + 100);
    `CHK(fault_red_fail_o, 1'h0)
    red_i[c] <= 1'h1;
    ms(600);
    {inhibit2_i, inhibit1_i} <= 2'h0;
    ms(10);
    red_i[c] <= 1'h0;
    ms(lo);
    `CHK(fault_red_fail_o, 1'h0)
    ms(hi - lo + 20);
    `CHK(fault_red_fail_o, 1'h1)
    `CHK(fail_chan_o[c], 1'h1)
    red_i[c] <= 1'h1;
    ms(600);
    `CHK(stat_red_o[c], 1'h0)
    rreset;
    `CHK(fault_red_fail_o, 1'h0)
    `CHK(stat_red_o[c], 1'h1)
    c = 12 + $urandom % 6;
    clear_en_i <= 18'h0;
    grn_i[c] <= 1'h1;
    ms(150);
    grn_i[c] <= 1'h0;
    ms(900);
    `CHK(fault_dual_o, 1'h0)
    grn_i[c] <= 1'h1;
    ms(1000);
    `CHK(fault_dual_o, 1'h1)
    `CHK(fail_chan_o[c], 1'h1)
    grn_i[c] <= 1'h0;
    ms(600);
    `CHK(stat_grn_o[c], 1'h1)
    rreset;
    // Arrow head: a source green shows up on the mapped arrow channel
    c = $urandom % 2;
    n = c ? 8 : 0;
    arrow_head_compact_mode_i <= 1'(c);
    arrow_phase_en_i <= 4'h1;
    red_i[n] <= 1'h0;
    grn_i[n] <= 1'h1;
    ms(1000);
    `CHK(fault_dual_o, 1'h1)
    `CHK(fail_chan_o[8 - n], 1'h1)
    `CHK(fail_chan_o[n], 1'h0)
    red_i[n] <= 1'h1;
    grn_i[n] <= 1'h0;
    ms(600);
    rreset;
    clear_en_i <= 18'h3ffff;
    c = 12 + $urandom % 6;
    yellow_inhibit_i[c] <= 1'h0;
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        rreset;
        yellow_inhibit_i[c] <= 1'h1;
      end
      red_i[c] <= 1'h0;
      grn_i[c] <= 1'h1;
      ms(700);
      grn_i[c] <= 1'h0;
      yel_i[c] <= 1'h1;
      ms(700);
      `CHK(stat_yel_o[c], 1'h1)
      ms(k == 0 ? 2600 : 300);
      yel_i[c] <= 1'h0;
      red_i[c] <= 1'h1;
      ms(800);
      `CHK(fault_clear_o, 1'(k == 1))
    end
    rreset;
    cfg_i <= ~cfg_i;
    n = 0;
    while (fault_cfg_o !== 1'h1 && n < 3000 * MS) begin
      @(posedge clk_sys_i);
      n++;
    end
    `CHK(fault_cfg_o, 1'h1)
    rreset;
    `CHK(fault_cfg_o, 1'h1)
    seen = program_card_led_o;
    ms(250);
    `CHK(program_card_led_o, !seen)
    panel_reset_i <= 1'h1;
    ms(2000);
    panel_reset_i <= 1'h0;
    ms(5);
    `CHK(fault_cfg_o, 1'h1)
    panel_reset_i <= 1'h1;
    ms(3100);
    panel_reset_i <= 1'h0;
    ms(5);
    `CHK(fault_cfg_o, 1'h0)
    `CHK(program_card_led_o, 1'h0)
    red_interface_cable_i <= 1'h0;
    ms(5);
    red_interface_cable_i <= 1'h1;
    ms(100);
    `CHK(fault_cable_o, 1'h1)
    `CHK(cabinet_flash_o, 1'h1)
    rreset;
    `CHK(fault_cable_o, 1'h0)
    complete_run;
  end
  // Hang guard, about a tenth past the expected run of some 85000 cycles
  initial begin
    repeat (95000) @(posedge clk_sys_i);
    n_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
